/* File: design/flash_seq_pkg.sv */
// Shared constants and types for the flash command sequencer and its master
package flash_seq_pkg;

  // ----------------------------------------------------------------
  // Array organisation
  // ----------------------------------------------------------------
  localparam int          N_PRI        = 4;
  localparam int          N_SEC        = 2;
  localparam int          N_SECT       = N_PRI + N_SEC;
  localparam int          SECT_AW      = 4;

  // ----------------------------------------------------------------
  // Command bytes and decoded addresses
  // ----------------------------------------------------------------
  localparam logic [7:0]  CMD_UNLOCK1  = 8'haa;
  localparam logic [7:0]  CMD_UNLOCK2  = 8'h55;
  localparam logic [7:0]  CMD_PROT     = 8'h90;
  localparam logic [7:0]  CMD_PROG     = 8'ha0;
  localparam logic [7:0]  CMD_ERASE    = 8'h80;
  localparam logic [7:0]  CMD_SECT     = 8'h30;
  localparam logic [7:0]  CMD_BULK     = 8'h10;
  localparam logic [7:0]  CMD_SUSP     = 8'hb0;
  localparam logic [7:0]  CMD_RESUME   = 8'h30;
  localparam logic [7:0]  CMD_RESET    = 8'hf0;
  localparam logic [11:0] ADDR_UNLOCK1 = 12'h555;
  localparam logic [11:0] ADDR_UNLOCK2 = 12'haaa;
  localparam logic [7:0]  ADDR_PROT    = 8'h02;
  localparam logic [7:0]  PROT_YES     = 8'h01;
  localparam logic [7:0]  PROT_NO      = 8'h00;
  localparam logic [7:0]  ERASED       = 8'hff;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_HZ       = 10_000_000;
  localparam int          WIN_US       = 80;
  localparam int          WIN_CYC      = WIN_US * (CLK_HZ / 1_000_000);
  localparam int          TIMEOUT_CYC  = 64;
  localparam int          PROG_CYC     = 16;
  localparam int          ERASE_CYC    = 256;
  localparam int          CNT_W        = 16;

  // ----------------------------------------------------------------
  // User commands of the master end
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    C_READ   = 4'h0,
    C_PROT   = 4'h1,
    C_PROG   = 4'h2,
    C_SERASE = 4'h3,
    C_BULK   = 4'h4,
    C_MORE   = 4'h5,
    C_SUSP   = 4'h6,
    C_RESUME = 4'h7,
    C_RESET  = 4'h8
  } cmd_t;

endpackage

/* File: design/flash_bus_if.sv */
// Bus between the microcontroller master and the flash sequencer
`timescale 1ns/1ps
interface flash_bus_if;
  logic        wr;
  logic        rd;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic [3:0]  primary_sector_selects;
  logic [1:0]  secondary_sector_selects;
  logic        ready_busy_out;

  modport dev (
    input  wr, rd, addr, wdata,
    input  primary_sector_selects, secondary_sector_selects,
    output rdata, ready_busy_out
  );

  modport host (
    output wr, rd, addr, wdata,
    output primary_sector_selects, secondary_sector_selects,
    input  rdata, ready_busy_out
  );
endinterface

/* File: design/flash_command_sequencer.sv */
// Flash command decoder, sector control and array store
// Function
// - Four primary, two secondary sectors, own selects
// - Protected sectors never programmed or erased
// - Sector erase, suspendable and resumable
// - Ready/busy low during program or erase
// - One select input per sector
// - Idle reads return array byte
// - Writes feed decoder, never stored directly
// - Execute only full sequence without timeout
// - Invalid byte or timeout returns read mode
// - Master opens with two unlock writes
// - Upper address ignored; select held throughout
// - Select group chooses target array
// - Unlock, 90h, then read status at 02h
// - Unlock, A0h, data at target, then poll
// - Erase six writes; 30h sector, 10h bulk
// - B0h, 30h, F0h single-write commands
// - Same command set on both arrays
// - Suspend only erasing; resume only suspended
// - Status 01h protected, 00h unprotected
// - Added sectors within 80 us window
// - Master resets after status read
`timescale 1ns/1ps
module flash_command_sequencer
  import flash_seq_pkg::*;
#(
  parameter int SAW     = flash_seq_pkg::SECT_AW,
  parameter int TMO     = flash_seq_pkg::TIMEOUT_CYC,
  parameter int PCYC    = flash_seq_pkg::PROG_CYC,
  parameter int ECYC    = flash_seq_pkg::ERASE_CYC,
  parameter int WCYC    = flash_seq_pkg::WIN_CYC
)(
  input  wire logic       clock_i,
  input  wire logic       rstn_i,
  input  wire logic       ce_i,
  input  wire logic [5:0] sector_protect_i,
  flash_bus_if.dev        bus
);
  import flash_seq_pkg::*;

  localparam int IW = SAW + 3;

  typedef enum logic [3:0] {
    D_READ  = 4'h0,
    D_U1    = 4'h1,
    D_U2    = 4'h2,
    D_PROT  = 4'h3,
    D_PDATA = 4'h4,
    D_E3    = 4'h5,
    D_E4    = 4'h6,
    D_E5    = 4'h7,
    D_EWIN  = 4'h8
  } dec_t;

  typedef enum logic [1:0] {
    E_IDLE  = 2'h0,
    E_PROG  = 2'h1,
    E_ERASE = 2'h2,
    E_SUSP  = 2'h3
  } eng_t;

  // ----------------------------------------------------------------
  // Sector decode
  // ----------------------------------------------------------------
  function automatic logic [2:0] sect_of(input logic [5:0] s);
    logic [2:0] r;
    r = 3'h0;
    for (int i = N_SECT - 1; i >= 0; i--)
      if (s[i])
        r = 3'(i);
    return r;
  endfunction

  logic [5:0]    sel;
  logic          pri_hit;
  logic          sec_hit;
  logic          wr_hit;
  logic          rd_hit;
  logic [2:0]    sect;
  logic [5:0]    sbit;
  logic [IW-1:0] idx;
  logic [11:0]   a12;
  logic [7:0]    wd;

  assign sel     = {bus.secondary_sector_selects,
                    bus.primary_sector_selects};
  assign pri_hit = |bus.primary_sector_selects;
  assign sec_hit = |bus.secondary_sector_selects;
  assign wr_hit  = bus.wr & (pri_hit | sec_hit);
  assign rd_hit  = bus.rd & (pri_hit | sec_hit);
  assign sect    = sect_of(sel);
  assign sbit    = 6'h01 << sect;
  assign idx     = {sect, bus.addr[SAW-1:0]};
  assign a12     = bus.addr[11:0];
  assign wd      = bus.wdata;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]     mem [0:(1<<IW)-1];
  dec_t           dec_r, dec_nxt;
  eng_t           eng_r, eng_nxt;
  logic [CNT_W-1:0] tmo_r, tmo_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [5:0]     mask_r, mask_nxt;
  logic [IW-1:0]  swp_r, swp_nxt;
  logic [IW-1:0]  pa_r, pa_nxt;
  logic [7:0]     pd_r, pd_nxt;
  logic [7:0]     rdata_r, rdata_nxt;
  logic           mem_we;
  logic [IW-1:0]  mem_wa;
  logic [7:0]     mem_wd;
  logic           start_erase;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    dec_nxt     = dec_r;
    eng_nxt     = eng_r;
    tmo_nxt     = tmo_r;
    cnt_nxt     = cnt_r;
    mask_nxt    = mask_r;
    swp_nxt     = swp_r;
    pa_nxt      = pa_r;
    pd_nxt      = pd_r;
    rdata_nxt   = rdata_r;
    mem_we      = 1'b0;
    mem_wa      = pa_r;
    mem_wd      = mem[pa_r] & pd_r;
    start_erase = 1'b0;

    // Reads: status at 02h in protection mode, else plain ROM read
    if (rd_hit)
    begin
      if (dec_r == D_PROT && bus.addr[7:0] == ADDR_PROT)
        rdata_nxt = sector_protect_i[sect] ? PROT_YES
                                           : PROT_NO;
      else
        rdata_nxt = mem[idx];
    end

    // Writes go only to the decoder
    if (wr_hit)
    begin
      tmo_nxt = '0;
      if (wd == CMD_RESET)
        dec_nxt = D_READ;
      else
        case (dec_r)
          D_READ:
          begin
            if (wd == CMD_UNLOCK1 && a12 == ADDR_UNLOCK1)
              dec_nxt = D_U1;
            else if (wd == CMD_SUSP && eng_r == E_ERASE)
              eng_nxt = E_SUSP;
            else if (wd == CMD_RESUME && eng_r == E_SUSP)
              eng_nxt = E_ERASE;
          end
          D_U1:
            dec_nxt = (wd == CMD_UNLOCK2 && a12 == ADDR_UNLOCK2)
                      ? D_U2 : D_READ;
          D_U2:
          begin
            dec_nxt = D_READ;
            if (a12 == ADDR_UNLOCK1)
            begin
              if (wd == CMD_PROT)
                dec_nxt = D_PROT;
              else if (wd == CMD_PROG)
                dec_nxt = D_PDATA;
              else if (wd == CMD_ERASE)
                dec_nxt = D_E3;
            end
          end
          D_PDATA:
          begin
            dec_nxt = D_READ;
            // Protected target: silently ignored, no busy phase
            if (eng_r == E_IDLE && !sector_protect_i[sect])
            begin
              eng_nxt = E_PROG;
              cnt_nxt = '0;
              pa_nxt  = idx;
              pd_nxt  = wd;
            end
          end
          D_E3:
            dec_nxt = (wd == CMD_UNLOCK1 && a12 == ADDR_UNLOCK1)
                      ? D_E4 : D_READ;
          D_E4:
            dec_nxt = (wd == CMD_UNLOCK2 && a12 == ADDR_UNLOCK2)
                      ? D_E5 : D_READ;
          D_E5:
          begin
            dec_nxt = D_READ;
            if (wd == CMD_SECT && eng_r == E_IDLE)
            begin
              dec_nxt  = D_EWIN;
              mask_nxt = sbit & ~sector_protect_i;
              cnt_nxt  = '0;
            end
            else if (wd == CMD_BULK && a12 == ADDR_UNLOCK1 &&
                     eng_r == E_IDLE)
            begin
              mask_nxt    = (pri_hit ? 6'h0f : 6'h30)
                            & ~sector_protect_i;
              start_erase = 1'b1;
            end
          end
          D_EWIN:
          begin
            if (wd == CMD_SECT)
            begin
              mask_nxt = mask_r | (sbit & ~sector_protect_i);
              cnt_nxt  = '0;
            end
            else
            begin
              dec_nxt  = D_READ;
              mask_nxt = '0;
            end
          end
          default:
            dec_nxt = D_READ;
        endcase
    end
    else if (dec_r != D_READ && dec_r != D_PROT && dec_r != D_EWIN)
    begin
      // Gap between bytes too long: drop the sequence
      if (tmo_r == CNT_W'(TMO - 1))
      begin
        dec_nxt = D_READ;
        tmo_nxt = '0;
      end
      else
        tmo_nxt = tmo_r + 1'b1;
    end

    // Collection window for further sectors
    if (dec_r == D_EWIN && !wr_hit)
    begin
      if (cnt_r == CNT_W'(WCYC - 1))
      begin
        dec_nxt     = D_READ;
        start_erase = 1'b1;
      end
      else
        cnt_nxt = cnt_r + 1'b1;
    end

    // Embedded algorithms
    case (eng_r)
      E_PROG:
      begin
        if (cnt_r == CNT_W'(PCYC - 1))
        begin
          mem_we  = 1'b1;
          eng_nxt = E_IDLE;
        end
        else
          cnt_nxt = cnt_r + 1'b1;
      end
      E_ERASE:
      begin
        if (cnt_r != CNT_W'(ECYC - 1))
          cnt_nxt = cnt_r + 1'b1;
        else
        begin
          mem_we = mask_r[swp_r[IW-1:SAW]];
          mem_wa = swp_r;
          mem_wd = ERASED;
          if (swp_r == IW'((N_SECT << SAW) - 1))
          begin
            eng_nxt  = E_IDLE;
            mask_nxt = '0;
          end
          else
            swp_nxt = swp_r + 1'b1;
        end
      end
      default:
        ;
    endcase

    // All-protected erase does nothing at all
    if (start_erase && mask_nxt != '0)
    begin
      eng_nxt = E_ERASE;
      cnt_nxt = '0;
      swp_nxt = '0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      dec_r   <= D_READ;
      eng_r   <= E_IDLE;
      tmo_r   <= '0;
      cnt_r   <= '0;
      mask_r  <= '0;
      swp_r   <= '0;
      pa_r    <= '0;
      pd_r    <= '0;
      rdata_r <= '0;
    end
    else if (ce_i)
    begin
      dec_r   <= dec_nxt;
      eng_r   <= eng_nxt;
      tmo_r   <= tmo_nxt;
      cnt_r   <= cnt_nxt;
      mask_r  <= mask_nxt;
      swp_r   <= swp_nxt;
      pa_r    <= pa_nxt;
      pd_r    <= pd_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Array content has no reset, as in real flash
  always_ff @(posedge clock_i)
  begin
    if (ce_i && mem_we)
      mem[mem_wa] <= mem_wd;
  end

  assign bus.rdata          = rdata_r;
  assign bus.ready_busy_out = !(eng_r == E_PROG ||
                                eng_r == E_ERASE);

endmodule

/* File: design/flash_bus_master.sv */
// Microcontroller side: turns user commands into flash bus sequences
`timescale 1ns/1ps
module flash_bus_master
  import flash_seq_pkg::*;
(
  input  wire logic                 clock_i,
  input  wire logic                 rstn_i,
  input  wire logic                 ce_i,
  input  wire logic                 cmd_valid_i,
  input  wire flash_seq_pkg::cmd_t  cmd_i,
  input  wire logic [15:0]          addr_i,
  input  wire logic [7:0]           data_i,
  input  wire logic [5:0]           sel_i,
  output logic                      cmd_ready_o,
  output logic [7:0]                rdata_o,
  output logic                      rdata_valid_o,
  output logic                      busy_o,
  flash_bus_if.host                 bus
);
  import flash_seq_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_WR   = 3'h1,
    H_RD   = 3'h2,
    H_WAIT = 3'h3,
    H_GET  = 3'h4,
    H_RST  = 3'h5,
    H_END  = 3'h6,
    H_POLL = 3'h7
  } hst_t;

  // ----------------------------------------------------------------
  // Sequence tables
  // ----------------------------------------------------------------
  function automatic logic [2:0] n_writes(input cmd_t c);
    case (c)
      C_READ:   return 3'h0;
      C_PROT:   return 3'h3;
      C_PROG:   return 3'h4;
      C_SERASE: return 3'h6;
      C_BULK:   return 3'h6;
      default:  return 3'h1;
    endcase
  endfunction

  function automatic logic [23:0] step(input cmd_t c, input logic [2:0] k,
                                       input logic [15:0] a,
                                       input logic [7:0] d);
    logic [3:0] hi;
    hi = a[15:12];
    case (c)
      C_MORE:   return {a, CMD_SECT};
      C_SUSP:   return {a, CMD_SUSP};
      C_RESUME: return {a, CMD_RESUME};
      C_RESET:  return {a, CMD_RESET};
      default:
        case (k)
          3'h0, 3'h3:
            if (k == 3'h3 && c == C_PROG)
              return {a, d};
            else
              return {hi, ADDR_UNLOCK1, CMD_UNLOCK1};
          3'h1, 3'h4:
            return {hi, ADDR_UNLOCK2, CMD_UNLOCK2};
          3'h2:
            return {hi, ADDR_UNLOCK1,
                    c == C_PROT ? CMD_PROT :
                    c == C_PROG ? CMD_PROG : CMD_ERASE};
          default:
            return c == C_BULK ? {hi, ADDR_UNLOCK1, CMD_BULK}
                               : {a, CMD_SECT};
        endcase
    endcase
  endfunction

  hst_t        st_r, st_nxt;
  cmd_t        cmd_r, cmd_nxt;
  logic [2:0]  k_r, k_nxt;
  logic [15:0] a_r, a_nxt;
  logic [7:0]  d_r, d_nxt;
  logic [5:0]  sel_r, sel_nxt;
  logic        wr_r, wr_nxt;
  logic        rd_r, rd_nxt;
  logic [15:0] ba_r, ba_nxt;
  logic [7:0]  bd_r, bd_nxt;
  logic [7:0]  rdata_r, rdata_nxt;
  logic        rv_r, rv_nxt;
  logic [23:0] s;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt    = st_r;
    cmd_nxt   = cmd_r;
    k_nxt     = k_r;
    a_nxt     = a_r;
    d_nxt     = d_r;
    sel_nxt   = sel_r;
    wr_nxt    = 1'b0;
    rd_nxt    = 1'b0;
    ba_nxt    = ba_r;
    bd_nxt    = bd_r;
    rdata_nxt = rdata_r;
    rv_nxt    = 1'b0;
    s         = step(cmd_r, k_r, a_r, d_r);
    case (st_r)
      H_IDLE:
        if (cmd_valid_i)
        begin
          cmd_nxt = cmd_i;
          a_nxt   = addr_i;
          d_nxt   = data_i;
          sel_nxt = sel_i;
          k_nxt   = '0;
          st_nxt  = n_writes(cmd_i) == 3'h0 ? H_RD : H_WR;
        end
      H_WR:
      begin
        wr_nxt = 1'b1;
        ba_nxt = s[23:8];
        bd_nxt = s[7:0];
        k_nxt  = k_r + 1'b1;
        if (k_r == n_writes(cmd_r) - 1'b1)
          st_nxt = cmd_r == C_PROT ? H_RD : H_END;
      end
      H_RD:
      begin
        rd_nxt = 1'b1;
        ba_nxt = cmd_r == C_PROT ? {a_r[15:8], ADDR_PROT} : a_r;
        st_nxt = H_WAIT;
      end
      H_WAIT:
        st_nxt = H_GET;
      H_GET:
      begin
        rdata_nxt = bus.rdata;
        rv_nxt    = 1'b1;
        st_nxt    = cmd_r == C_PROT ? H_RST : H_IDLE;
        if (cmd_r != C_PROT)
          sel_nxt = '0;
      end
      H_RST:
      begin
        wr_nxt = 1'b1;
        ba_nxt = a_r;
        bd_nxt = CMD_RESET;
        st_nxt = H_END;
      end
      H_END:
      begin
        sel_nxt = '0;
        st_nxt  = cmd_r == C_PROG ? H_POLL : H_IDLE;
      end
      H_POLL:
        if (bus.ready_busy_out)
          st_nxt = H_IDLE;
      default:
        st_nxt = H_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      st_r    <= H_IDLE;
      cmd_r   <= C_READ;
      k_r     <= '0;
      a_r     <= '0;
      d_r     <= '0;
      sel_r   <= '0;
      wr_r    <= 1'b0;
      rd_r    <= 1'b0;
      ba_r    <= '0;
      bd_r    <= '0;
      rdata_r <= '0;
      rv_r    <= 1'b0;
    end
    else if (ce_i)
    begin
      st_r    <= st_nxt;
      cmd_r   <= cmd_nxt;
      k_r     <= k_nxt;
      a_r     <= a_nxt;
      d_r     <= d_nxt;
      sel_r   <= sel_nxt;
      wr_r    <= wr_nxt;
      rd_r    <= rd_nxt;
      ba_r    <= ba_nxt;
      bd_r    <= bd_nxt;
      rdata_r <= rdata_nxt;
      rv_r    <= rv_nxt;
    end
  end

  assign bus.wr                       = wr_r;
  assign bus.rd                       = rd_r;
  assign bus.addr                     = ba_r;
  assign bus.wdata                    = bd_r;
  assign bus.primary_sector_selects   = sel_r[3:0];
  assign bus.secondary_sector_selects = sel_r[5:4];
  assign cmd_ready_o                  = st_r == H_IDLE;
  assign rdata_o                      = rdata_r;
  assign rdata_valid_o                = rv_r;
  assign busy_o                       = !bus.ready_busy_out;

endmodule

/* File: verif/flash_command_sequencer_properties.sv */
// Interface checker for the flash command sequencer bus
`timescale 1ns/1ps
module flash_command_sequencer_properties #(
  parameter int BUSY_MAX = 100
)(
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  input  wire logic        wr,
  input  wire logic        rd,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic [7:0]  rdata,
  input  wire logic [3:0]  primary_sector_selects,
  input  wire logic [1:0]  secondary_sector_selects,
  input  wire logic        ready_busy_out
);
  logic       sel;
  logic [7:0] low_cnt_r;

  assign sel = |{primary_sector_selects, secondary_sector_selects};

  // Saturates so a stuck busy cannot wrap back under the limit
  always_ff @(posedge clock_i or negedge rstn_i)
    if (!rstn_i)
      low_cnt_r <= 8'h00;
    else if (ready_busy_out)
      low_cnt_r <= 8'h00;
    else if (low_cnt_r != 8'hff)
      low_cnt_r <= low_cnt_r + 8'h01;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  // ----------------------------------------------------------------
  // Bus properties
  // ----------------------------------------------------------------
  a_rd_single_strobe: assert property (rd |=> !rd)
    else $error("read strobe longer than one cycle");
  a_rdata_hold: assert property (!(rd && sel) |=> $stable(rdata))
    else $error("read data changed without a read");
  a_sel_held: assert property (wr && $past(wr) |->
    $stable(primary_sector_selects) && $stable(secondary_sector_selects))
    else $error("sector select moved inside a command");
  a_strobe_selected: assert property ((wr || rd) |-> sel)
    else $error("strobe without a sector select");
  a_unlock_first: assert property (wr && !$past(wr) |->
    (wdata == 8'haa && addr[11:0] == 12'h555) ||
    wdata inside {8'hb0, 8'h30, 8'hf0})
    else $error("sequence opened without first unlock");
  a_unlock_second: assert property (wr && $past(wr) &&
    $past(wdata) == 8'haa |-> wdata == 8'h55 && addr[11:0] == 12'haaa)
    else $error("second unlock write wrong");
  a_busy_min_len: assert property ($fell(ready_busy_out) |=>
    !ready_busy_out [*8])
    else $error("busy pulse too short");
  a_busy_bounded: assert property (low_cnt_r <= BUSY_MAX)
    else $error("busy held beyond longest cycle");
  a_prot_value: assert property (rd && sel && addr[7:0] == 8'h02 &&
    wdata == 8'h90 |=> rdata inside {8'h00, 8'h01})
    else $error("protection status not 00h or 01h");
endmodule

/* File: verif/flash_command_sequencer_tb_top.sv */
// Bench joining the bus master end and the sequencer end
`timescale 1ns/1ps
module flash_command_sequencer_tb_top;
  import flash_seq_pkg::*;
  localparam int ECY  = 4;
  localparam int PCY  = 16;
  localparam int TMO  = 8;
  localparam int ELEN = ECY - 1 + 6 * (2 ** SECT_AW);
  logic        clock_i     = 1'b0;
  logic        rstn_i      = 1'b0;
  logic        cmd_valid_i = 1'b0;
  cmd_t        cmd_i       = C_READ;
  logic [15:0] addr_i      = 16'h0000;
  logic [7:0]  data_i      = 8'h00;
  logic [5:0]  sel_i       = 6'h00;
  logic [5:0]  prot_i      = 6'h00;
  logic        cmd_ready_o;
  logic        rdata_valid_o;
  logic        busy_o;
  logic [7:0]  rdata_o;
  logic [7:0]  got;
  int          busy_cnt    = 0;
  int          raw_low     = 0;
  int          error_cnt   = 0;
  int          comparisons = 0;

  flash_bus_if bus_if ();
  flash_bus_if raw_if ();

  flash_bus_master u_flash_bus_master (.clock_i(clock_i), .rstn_i(rstn_i),
    .ce_i(1'b1), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .addr_i(addr_i),
    .data_i(data_i), .sel_i(sel_i), .cmd_ready_o(cmd_ready_o),
    .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o), .busy_o(busy_o),
    .bus(bus_if));
  flash_command_sequencer #(.TMO(TMO), .PCYC(PCY), .ECYC(ECY), .WCYC(20))
    u_flash_command_sequencer (.clock_i(clock_i), .rstn_i(rstn_i),
    .ce_i(1'b1), .sector_protect_i(prot_i), .bus(bus_if));
  // Second end driven straight by the bench to break the master's rules
  flash_command_sequencer #(.TMO(TMO), .PCYC(PCY), .ECYC(ECY), .WCYC(20))
    u_flash_command_sequencer_raw (.clock_i(clock_i), .rstn_i(rstn_i),
    .ce_i(1'b1), .sector_protect_i(prot_i), .bus(raw_if));
  flash_command_sequencer_properties #(.BUSY_MAX(ELEN))
    u_flash_command_sequencer_properties (.clock_i(clock_i),
    .rstn_i(rstn_i), .wr(bus_if.wr), .rd(bus_if.rd), .addr(bus_if.addr),
    .wdata(bus_if.wdata), .rdata(bus_if.rdata),
    .primary_sector_selects(bus_if.primary_sector_selects),
    .secondary_sector_selects(bus_if.secondary_sector_selects),
    .ready_busy_out(bus_if.ready_busy_out));

  always #50 clock_i = ~clock_i;

  // Pre-edge values, so no race with the design's registers
  always @(posedge clock_i)
  begin
    if (busy_o === 1'b1) busy_cnt++;
    if (raw_if.ready_busy_out === 1'b0) raw_low++;
    if (rdata_valid_o === 1'b1) got = rdata_o;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic step(input int k);
    repeat (k) @(posedge clock_i) #1;
  endtask

  task automatic check_byte(input string what, input logic [7:0] exp,
                            input logic [7:0] seen);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic check_count(input string what, input int exp, input int seen);
    comparisons++;
    if (seen != exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, seen);
    end
  endtask

  task automatic run(input cmd_t c, input logic [15:0] a,
                     input logic [7:0] d, input logic [5:0] s);
    int n;
    cmd_i       = c;
    addr_i      = a;
    data_i      = d;
    sel_i       = s;
    cmd_valid_i = 1'b1;
    step(1);
    cmd_valid_i = 1'b0;
    for (n = 0; n < 300 && cmd_ready_o !== 1'b1; n++)
      step(1);
    check_count("ready", 1, cmd_ready_o === 1'b1);
    step(1);
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [5:0] s,
                        input logic [7:0] exp, input string what);
    run(C_READ, a, 8'h00, s);
    check_byte(what, exp, got);
  endtask

  task automatic wr_raw(input logic [15:0] a, input logic [7:0] d);
    raw_if.wr    = 1'b1;
    raw_if.addr  = a;
    raw_if.wdata = d;
    step(1);
    raw_if.wr    = 1'b0;
    raw_if.addr  = ~a;
    raw_if.wdata = ~d;
    step(1);
  endtask

  task automatic rd_raw(input logic [15:0] a, input logic [7:0] exp,
                        input string what);
    raw_if.rd   = 1'b1;
    raw_if.addr = a;
    step(1);
    raw_if.rd   = 1'b0;
    raw_if.addr = ~a;
    step(1);
    check_byte(what, exp, raw_if.rdata);
  endtask

  task automatic prog_raw(input logic [15:0] a, input logic [7:0] d,
                          input logic [7:0] b2, input int gap);
    wr_raw(16'h0555, 8'haa);
    wr_raw(16'h0aaa, b2);
    wr_raw(16'h0555, 8'ha0);
    step(gap);
    wr_raw(a, d);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_bulk_prog;
    busy_cnt = 0;
    run(C_BULK, 16'h0555, 8'h00, 6'h01);
    step(ELEN + 30);
    check_count("bulk busy", ELEN, busy_cnt);
    run(C_BULK, 16'h0555, 8'h00, 6'h10);
    step(ELEN + 30);
    busy_cnt = 0;
    run(C_PROG, 16'hf003, 8'h5a, 6'h01);
    check_count("prog busy", PCY, busy_cnt);
    rd_chk(16'h0003, 6'h01, 8'h5a, "primary byte");
    rd_chk(16'h0003, 6'h10, 8'hff, "secondary byte");
    $display("t_bulk_prog done");
  endtask

  task automatic t_protect;
    prot_i = 6'h02;
    run(C_PROT, 16'h0002, 8'h00, 6'h02);
    check_byte("status protected", 8'h01, got);
    run(C_PROT, 16'h0002, 8'h00, 6'h01);
    check_byte("status open", 8'h00, got);
    busy_cnt = 0;
    run(C_PROG, 16'h0014, 8'h00, 6'h02);
    step(4);
    check_count("protected prog busy", 0, busy_cnt);
    rd_chk(16'h0014, 6'h02, 8'hff, "protected byte");
    prot_i = 6'h00;
    $display("t_protect done");
  endtask

  task automatic t_erase_suspend;
    run(C_PROG, 16'h0001, 8'h96, 6'h04);
    run(C_PROG, 16'h0001, 8'h12, 6'h10);
    run(C_PROG, 16'h0001, 8'h34, 6'h20);
    busy_cnt = 0;
    run(C_SERASE, 16'h0001, 8'h00, 6'h10);
    run(C_MORE, 16'h0001, 8'h00, 6'h20);
    step(40);
    run(C_SUSP, 16'h0000, 8'h00, 6'h10);
    check_byte("suspended ready", 8'h00, {7'h00, busy_o});
    rd_chk(16'h0001, 6'h04, 8'h96, "read in suspend");
    run(C_RESUME, 16'h0000, 8'h00, 6'h10);
    step(ELEN);
    check_count("erase busy", ELEN, busy_cnt);
    rd_chk(16'h0001, 6'h10, 8'hff, "erased first");
    rd_chk(16'h0001, 6'h20, 8'hff, "erased added");
    $display("t_erase_suspend done");
  endtask

  task automatic t_raw;
    raw_if.primary_sector_selects = 4'h1;
    wr_raw(16'h0555, 8'haa);
    wr_raw(16'h0aaa, 8'h55);
    wr_raw(16'h0555, 8'h80);
    wr_raw(16'h0555, 8'haa);
    wr_raw(16'h0aaa, 8'h55);
    wr_raw(16'h0555, 8'h10);
    step(ELEN + 10);
    raw_low = 0;
    wr_raw(16'h0001, 8'h00);
    rd_raw(16'h0001, 8'hff, "plain write");
    prog_raw(16'h0002, 8'h00, 8'h55, TMO);
    rd_raw(16'h0002, 8'hff, "late byte");
    prog_raw(16'h0003, 8'h00, 8'h56, 0);
    rd_raw(16'h0003, 8'hff, "bad unlock");
    wr_raw(16'h0000, 8'hb0);
    check_count("idle suspend busy", 0, raw_low);
    prog_raw(16'h0005, 8'h3c, 8'h55, TMO - 4);
    step(PCY + 4);
    check_count("raw prog busy", PCY, raw_low);
    rd_raw(16'h0005, 8'h3c, "raw prog");
    $display("t_raw done");
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    raw_if.wr = 1'b0;
    raw_if.rd = 1'b0;
    raw_if.addr = 16'h0000;
    raw_if.wdata = 8'h00;
    raw_if.primary_sector_selects = 4'h0;
    raw_if.secondary_sector_selects = 2'h0;
    repeat (16) @(posedge clock_i);
    #1;
    rstn_i = 1'b1;
    step(2);
    t_bulk_prog;
    t_protect;
    t_erase_suspend;
    t_raw;
    tally_and_finish;
  end

  // Tests need about 800 cycles; this allows over ten times that
  initial
  begin
    #1_000_000;
    error_cnt++;
    tally_and_finish;
  end
endmodule
